// file: core/cx_pkg.sv
// shared constants and types for the transfer, test and trap executor
package cx_pkg;
  localparam logic [7:0]  OP_SOFT_TRAP         = 8'h83;
  localparam logic [7:0]  OP_ACC_TO_FLAGS      = 8'h84;
  localparam logic [7:0]  OP_FLAGS_TO_ACC      = 8'h85;
  localparam logic [7:0]  OP_ACC_TO_INDEX_LOW  = 8'h97;
  localparam logic [7:0]  OP_INDEX_LOW_TO_ACC  = 8'h9F;
  localparam logic [7:0]  OP_STACKPTR_TO_INDEX = 8'h95;
  localparam logic [7:0]  OP_INDEX_TO_STACKPTR = 8'h94;
  localparam logic [7:0]  OP_CHECK_DIR         = 8'h3D;
  localparam logic [7:0]  OP_CHECK_ACC         = 8'h4D;
  localparam logic [7:0]  OP_CHECK_IDX         = 8'h5D;
  localparam logic [7:0]  OP_CHECK_XOFS        = 8'h6D;
  localparam logic [7:0]  OP_CHECK_XPTR        = 8'h7D;
  localparam logic [7:0]  OP_CHECK_SOFS        = 8'h6D;
  localparam logic [7:0]  OP_PREBYTE           = 8'h9E;

  localparam logic [3:0]  CYC_SOFT_TRAP        = 4'h9;
  localparam logic [3:0]  CYC_ACC_TO_FLAGS     = 4'h2;
  localparam logic [3:0]  CYC_ONE              = 4'h1;
  localparam logic [3:0]  CYC_TWO              = 4'h2;
  localparam logic [3:0]  CYC_CHECK_DIR        = 4'h3;
  localparam logic [3:0]  CYC_CHECK_XOFS       = 4'h3;
  localparam logic [3:0]  CYC_CHECK_XPTR       = 4'h2;
  localparam logic [3:0]  CYC_CHECK_SOFS       = 4'h4;

  localparam int          FLG_V                = 7;
  localparam int          FLG_H                = 4;
  localparam int          FLG_I                = 3;
  localparam int          FLG_N                = 2;
  localparam int          FLG_Z                = 1;
  localparam int          FLG_C                = 0;
  localparam logic [7:0]  FLAGS_FIXED          = 8'h60;
  localparam logic [7:0]  FLAGS_RST            = 8'h68;

  localparam logic [15:0] SP_RST               = 16'h00FF;
  localparam logic [15:0] PC_RST               = 16'h0000;
  localparam logic [15:0] VEC_HI_ADDR          = 16'hFFFC;
  localparam logic [15:0] VEC_LO_ADDR          = 16'hFFFD;
  localparam logic [15:0] ONE16                = 16'h0001;
  localparam logic [15:0] TWO16                = 16'h0002;
  localparam logic [15:0] THREE16              = 16'h0003;
  localparam logic [15:0] PUSHES16             = 16'h0005;

  typedef enum logic [3:0] {
    K_NOP, K_TRAP, K_A2F, K_A2X, K_F2A, K_X2A, K_S2X, K_X2S,
    K_CKDIR, K_CKACC, K_CKIDX, K_CKXOF, K_CKXPT, K_CKSOF
  } cx_kind_t;

  typedef enum logic {ST_IDLE, ST_RUN} cx_state_t;
endpackage : cx_pkg

// file: core/cx_nz_eval.sv
// negative and zero evaluation of a byte tested against zero
module cx_nz_eval
  import cx_pkg::*;
(
  input  wire logic [7:0] i_value,
  output logic            o_neg,
  output logic            o_zero
);
  // subtracting zero leaves the byte itself
  assign o_neg  = i_value[7];
  assign o_zero = (i_value == 8'h00);
endmodule : cx_nz_eval

// file: core/cx_exec_unit.sv
// executor for trap, register transfers and the test instruction
//
// Overview of operation
// - 83 traps: nine cycles, five pushes, SP down
// - 84 copies accumulator into flags with bits 6 and 5 forced set, two cycles
// - 97 copies accumulator to index low, one cycle
// - 85 copies flags to accumulator, one cycle
// - test clears V, sets N Z, keeps C
// - test opcodes and cycle counts per mode
// - 95 loads index with SP plus one
// - 9F copies index low to accumulator
// - 94 loads SP with index minus one
// - direct mode: operand byte is address
// - byte offset plus index forms address
// - byte offset after prebyte plus SP
// - no offset mode: index is address
module cx_exec_unit
  import cx_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_CORE_CE,
  input  wire logic        I_GO,
  input  wire logic [7:0]  I_OPCODE,
  input  wire logic        I_PREBYTE,
  input  wire logic [7:0]  I_MEM_RDATA,
  output logic      [15:0] O_MEM_ADDR,
  output logic      [7:0]  O_MEM_WDATA,
  output logic             O_MEM_WE,
  output logic             O_MEM_RE,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic      [7:0]  O_ACC,
  output logic      [15:0] O_INDEX,
  output logic      [15:0] O_SP,
  output logic      [15:0] O_PC,
  output logic      [7:0]  O_FLAGS
);
  cx_state_t   state;
  cx_kind_t    kind;
  cx_kind_t    kind_q;
  logic [3:0]  ncyc;
  logic [3:0]  last;
  logic [3:0]  step;
  logic        busy;
  logic        done;
  logic [7:0]  acc;
  logic [15:0] index_reg;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic        mem_re;
  logic [7:0]  vec_hi;
  logic [7:0]  push_byte;
  logic [7:0]  chk_byte;
  logic        chk_neg;
  logic        chk_zero;
  logic        run;
  logic        fin;

  assign run = (state == ST_RUN);
  assign fin = run && (step == last);

  // opcode decode with cycle count
  always_comb
  begin
    kind = K_NOP;
    ncyc = CYC_ONE;
    if (I_PREBYTE)
    begin
      if (I_OPCODE == OP_CHECK_SOFS)
      begin
        kind = K_CKSOF;
        ncyc = CYC_CHECK_SOFS;
      end
    end
    else
    begin
      case (I_OPCODE)
        OP_SOFT_TRAP:         begin kind = K_TRAP; ncyc = CYC_SOFT_TRAP; end
        OP_ACC_TO_FLAGS:      begin kind = K_A2F; ncyc = CYC_ACC_TO_FLAGS; end
        OP_ACC_TO_INDEX_LOW:  begin kind = K_A2X; ncyc = CYC_ONE; end
        OP_FLAGS_TO_ACC:      begin kind = K_F2A; ncyc = CYC_ONE; end
        OP_INDEX_LOW_TO_ACC:  begin kind = K_X2A; ncyc = CYC_ONE; end
        OP_STACKPTR_TO_INDEX: begin kind = K_S2X; ncyc = CYC_TWO; end
        OP_INDEX_TO_STACKPTR: begin kind = K_X2S; ncyc = CYC_TWO; end
        OP_CHECK_DIR:         begin kind = K_CKDIR; ncyc = CYC_CHECK_DIR; end
        OP_CHECK_ACC:         begin kind = K_CKACC; ncyc = CYC_ONE; end
        OP_CHECK_IDX:         begin kind = K_CKIDX; ncyc = CYC_ONE; end
        OP_CHECK_XOFS:        begin kind = K_CKXOF; ncyc = CYC_CHECK_XOFS; end
        OP_CHECK_XPTR:        begin kind = K_CKXPT; ncyc = CYC_CHECK_XPTR; end
        default:              begin kind = K_NOP; ncyc = CYC_ONE; end
      endcase
    end
  end

  // sequencing of instruction steps
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state  <= ST_IDLE;
      kind_q <= K_NOP;
      last   <= 4'h0;
      step   <= 4'h0;
      busy   <= 1'b0;
      done   <= 1'b0;
    end
    else if (I_CORE_CE)
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (I_GO)
          begin
            kind_q <= kind;
            last   <= 4'(ncyc - 4'h1);
            step   <= 4'h0;
            busy   <= 1'b1;
            state  <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (step == last)
          begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end
          else
            step <= 4'(step + 4'h1);
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // bytes stacked by the trap, lowest counter byte first
  always_comb
  begin
    case (step)
      4'h1:    push_byte = pc[7:0];
      4'h2:    push_byte = pc[15:8];
      4'h3:    push_byte = index_reg[7:0];
      4'h4:    push_byte = acc;
      default: push_byte = flags;
    endcase
  end

  // operand of the test instruction
  always_comb
  begin
    case (kind_q)
      K_CKACC: chk_byte = acc;
      K_CKIDX: chk_byte = index_reg[7:0];
      default: chk_byte = I_MEM_RDATA;
    endcase
  end

  cx_nz_eval u_nz (
    .i_value (chk_byte),
    .o_neg   (chk_neg),
    .o_zero  (chk_zero)
  );

  // memory port addressing and stacking writes
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      mem_addr  <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
      vec_hi    <= 8'h00;
    end
    else if (I_CORE_CE)
    begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      if (run)
      begin
        case (kind_q)
          K_TRAP:
          begin
            if (step >= 4'h1 && step <= 4'h5)
            begin
              mem_we    <= 1'b1;
              mem_addr  <= sp;
              mem_wdata <= push_byte;
            end
            else if (step == 4'h6)
            begin
              mem_re   <= 1'b1;
              mem_addr <= VEC_HI_ADDR;
            end
            else if (step == 4'h7)
            begin
              vec_hi   <= I_MEM_RDATA;
              mem_re   <= 1'b1;
              mem_addr <= VEC_LO_ADDR;
            end
          end
          K_CKDIR, K_CKXOF:
          begin
            if (step == 4'h0)
            begin
              mem_re   <= 1'b1;
              mem_addr <= 16'(pc + ONE16);
            end
            else if (step == 4'h1)
            begin
              mem_re <= 1'b1;
              if (kind_q == K_CKDIR)
                mem_addr <= {8'h00, I_MEM_RDATA};
              else
                mem_addr <= 16'(index_reg + {8'h00, I_MEM_RDATA});
            end
          end
          K_CKXPT:
          begin
            if (step == 4'h0)
            begin
              mem_re   <= 1'b1;
              mem_addr <= index_reg;
            end
          end
          K_CKSOF:
          begin
            if (step == 4'h1)
            begin
              mem_re   <= 1'b1;
              mem_addr <= 16'(pc + TWO16);
            end
            else if (step == 4'h2)
            begin
              mem_re   <= 1'b1;
              mem_addr <= 16'(sp + {8'h00, I_MEM_RDATA});
            end
          end
          default: mem_re <= 1'b0;
        endcase
      end
    end
  end

  // architectural registers
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      acc       <= 8'h00;
      index_reg <= 16'h0000;
      sp        <= SP_RST;
      pc        <= PC_RST;
      flags     <= FLAGS_RST;
    end
    else if (I_CORE_CE && run)
    begin
      if (kind_q == K_TRAP)
      begin
        if (step == 4'h0)
          pc <= 16'(pc + ONE16);
        else if (step >= 4'h1 && step <= 4'h5)
          sp <= 16'(sp - ONE16);
        else if (step == 4'h6)
          flags[FLG_I] <= 1'b1;
        else if (step == 4'h8)
          pc <= {vec_hi, I_MEM_RDATA};
      end
      else if (fin)
      begin
        case (kind_q)
          K_A2F: flags <= acc | FLAGS_FIXED;
          K_A2X: index_reg[7:0] <= acc;
          K_F2A: acc <= flags;
          K_X2A: acc <= index_reg[7:0];
          K_S2X: index_reg <= 16'(sp + ONE16);
          K_X2S: sp <= 16'(index_reg - ONE16);
          K_CKDIR, K_CKACC, K_CKIDX, K_CKXOF, K_CKXPT, K_CKSOF:
          begin
            flags[FLG_V] <= 1'b0;
            flags[FLG_N] <= chk_neg;
            flags[FLG_Z] <= chk_zero;
          end
          default: flags <= flags;
        endcase
        case (kind_q)
          K_CKDIR, K_CKXOF: pc <= 16'(pc + TWO16);
          K_CKSOF:          pc <= 16'(pc + THREE16);
          default:        pc <= 16'(pc + ONE16);
        endcase
      end
    end
  end

  assign O_MEM_ADDR  = mem_addr;
  assign O_MEM_WDATA = mem_wdata;
  assign O_MEM_WE    = mem_we;
  assign O_MEM_RE    = mem_re;
  assign O_BUSY      = busy;
  assign O_DONE      = done;
  assign O_ACC       = acc;
  assign O_INDEX     = index_reg;
  assign O_SP        = sp;
  assign O_PC        = pc;
  assign O_FLAGS     = flags;

  chk_trap_length: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (state == ST_IDLE && I_GO && kind == K_TRAP)
      |=> O_BUSY [*8] ##1 O_BUSY ##1 O_DONE)
    else $error("trap did not finish in nine cycles");

  chk_trap_stack: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    O_MEM_WE |-> O_SP == 16'(O_MEM_ADDR - ONE16))
    else $error("push address and stack pointer disagree");

  chk_trap_vector: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_TRAP)
      |-> O_FLAGS[FLG_I] && O_PC == {vec_hi, $past(I_MEM_RDATA)}
          && O_SP == 16'($past(O_SP, 10) - PUSHES16))
    else $error("trap end state wrong");

  chk_acc_flags: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_A2F) |-> O_FLAGS == (O_ACC | FLAGS_FIXED))
    else $error("flags not copied from accumulator");

  chk_acc_index: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_A2X)
      |-> O_INDEX[7:0] == O_ACC && O_FLAGS == $past(O_FLAGS))
    else $error("index low not copied from accumulator");

  chk_flags_acc: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_F2A) |-> O_ACC == O_FLAGS)
    else $error("accumulator not copied from flags");

  chk_test_flags: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_CKACC)
      |-> !O_FLAGS[FLG_V] && O_FLAGS[FLG_N] == O_ACC[7]
          && O_FLAGS[FLG_Z] == (O_ACC == 8'h00)
          && O_FLAGS[FLG_C] == $past(O_FLAGS[FLG_C]))
    else $error("test flags wrong");

  chk_test_direct: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (state == ST_IDLE && I_GO && kind == K_CKDIR) |-> ##4 O_DONE)
    else $error("direct test not three cycles");

  chk_sp_index: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_S2X) |-> O_INDEX == 16'(O_SP + ONE16))
    else $error("index not stack pointer plus one");

  chk_index_acc: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_X2A) |-> O_ACC == O_INDEX[7:0])
    else $error("accumulator not copied from index low");

  chk_index_sp: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (O_DONE && kind_q == K_X2S) |-> O_SP == 16'(O_INDEX - ONE16))
    else $error("stack pointer not index minus one");

  chk_direct_addr: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (run && kind_q == K_CKDIR && step == 4'h1)
      |=> O_MEM_RE && O_MEM_ADDR == {8'h00, $past(I_MEM_RDATA)})
    else $error("direct address wrong");

  chk_offset_addr: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (run && kind_q == K_CKXOF && step == 4'h1)
      |=> O_MEM_ADDR == 16'(O_INDEX + {8'h00, $past(I_MEM_RDATA)}))
    else $error("indexed offset address wrong");

  chk_stack_addr: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (run && kind_q == K_CKSOF && step == 4'h2)
      |=> O_MEM_ADDR == 16'(O_SP + {8'h00, $past(I_MEM_RDATA)}))
    else $error("stack offset address wrong");

  chk_plain_index: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_ARST_N || !I_CORE_CE)
    (run && kind_q == K_CKXPT && step == 4'h0)
      |=> O_MEM_RE && O_MEM_ADDR == O_INDEX)
    else $error("no offset address wrong");
endmodule : cx_exec_unit

// file: test/cx_exec_unit_tb.sv
// self-checking bench for the transfer, test and trap executor
module cx_exec_unit_tb
  import cx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        arst_n;
  logic        ce;
  logic        go;
  logic [7:0]  opcode;
  logic        prebyte;
  logic [7:0]  rdata;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic        re;
  logic        busy;
  logic        done;
  logic [7:0]  acc;
  logic [15:0] idx;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [7:0]  flags;
  logic [7:0]  mem [0:65535];
  logic [15:0] rlog [$];
  logic [39:0] wlog [$];
  logic [15:0] exp_rd [$];
  logic [23:0] exp_wr [$];
  logic [7:0]  acc_m;
  logic [15:0] idx_m;
  logic [15:0] sp_m;
  logic [15:0] pc_m;
  logic [7:0]  flg_m;
  int          bad_count = 0;
  int          cmp_count = 0;

  cx_exec_unit DUT (
    .I_CORE_CLK  (clk),
    .I_ARST_N    (arst_n),
    .I_CORE_CE   (ce),
    .I_GO        (go),
    .I_OPCODE    (opcode),
    .I_PREBYTE   (prebyte),
    .I_MEM_RDATA (rdata),
    .O_MEM_ADDR  (addr),
    .O_MEM_WDATA (wdata),
    .O_MEM_WE    (we),
    .O_MEM_RE    (re),
    .O_BUSY      (busy),
    .O_DONE      (done),
    .O_ACC       (acc),
    .O_INDEX     (idx),
    .O_SP        (sp),
    .O_PC        (pc),
    .O_FLAGS     (flags)
  );

  // zero-latency memory
  assign rdata = mem[addr];

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // bus activity log
  always @(posedge clk)
  begin
    if (re === 1'b1)
      rlog.push_back(addr);
    if (we === 1'b1)
    begin
      wlog.push_back({addr, wdata, sp});
      mem[addr] <= wdata;
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    go     <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    cmp({12'h000, busy, done, we, re}, 16'h0000, "reset strobes");
    cmp({acc, flags}, {8'h00, FLAGS_RST}, "reset acc flags");
    cmp(idx, 16'h0000, "reset index");
    cmp(sp, SP_RST, "reset sp");
    cmp(pc, PC_RST, "reset pc");
    @(posedge clk);
    arst_n <= 1'b1;
    acc_m = 8'h00;
    idx_m = 16'h0000;
    sp_m  = SP_RST;
    pc_m  = PC_RST;
    flg_m = FLAGS_RST;
  endtask : do_reset

  // one instruction: model, drive, judge
  task automatic exec(input logic [7:0] op, input logic pre,
                      input int hold, input int stall);
    int          n;
    int          cyc;
    int          step;
    logic [7:0]  v;
    logic [15:0] ea;
    logic [15:0] ret;
    cyc  = 1;
    step = pre ? 2 : 1;
    v    = 8'h00;
    ea   = 16'h0000;
    ret  = pc_m + ONE16;
    exp_rd.delete();
    exp_wr.delete();
    case (op)
      OP_SOFT_TRAP:
      begin
        cyc = 9;
        exp_wr = '{{sp_m, ret[7:0]}, {sp_m - ONE16, ret[15:8]},
                   {sp_m - TWO16, idx_m[7:0]}, {sp_m - THREE16, acc_m},
                   {sp_m - 16'h0004, flg_m}};
        exp_rd = '{VEC_HI_ADDR, VEC_LO_ADDR};
        sp_m = sp_m - PUSHES16;
        flg_m[FLG_I] = 1'b1;
      end
      OP_ACC_TO_FLAGS:
      begin
        cyc = 2;
        flg_m = acc_m | FLAGS_FIXED;
      end
      OP_FLAGS_TO_ACC: acc_m = flg_m;
      OP_ACC_TO_INDEX_LOW: idx_m[7:0] = acc_m;
      OP_INDEX_LOW_TO_ACC: acc_m = idx_m[7:0];
      OP_STACKPTR_TO_INDEX:
      begin
        cyc = 2;
        idx_m = sp_m + ONE16;
      end
      OP_INDEX_TO_STACKPTR:
      begin
        cyc = 2;
        sp_m = idx_m - ONE16;
      end
      OP_CHECK_ACC: v = acc_m;
      OP_CHECK_IDX: v = idx_m[7:0];
      OP_CHECK_DIR:
      begin
        cyc = 3;
        step = step + 1;
        ea = {8'h00, mem[ret]};
        exp_rd = '{ret, ea};
      end
      OP_CHECK_XPTR:
      begin
        cyc = 2;
        ea = idx_m;
        exp_rd = '{ea};
      end
      OP_CHECK_XOFS:
      begin
        cyc = pre ? 4 : 3;
        step = step + 1;
        ea = (pre ? sp_m : idx_m) + {8'h00, mem[pc_m + 16'(step - 1)]};
        exp_rd = '{pc_m + 16'(step - 1), ea};
      end
      default: ;
    endcase
    if (op inside {OP_CHECK_DIR, OP_CHECK_XPTR, OP_CHECK_XOFS})
      v = mem[ea];
    if (op inside {OP_CHECK_DIR, OP_CHECK_ACC, OP_CHECK_IDX,
                   OP_CHECK_XOFS, OP_CHECK_XPTR})
      flg_m = {1'b0, flg_m[6:3], v[7], v == 8'h00, flg_m[0]};
    if (op == OP_SOFT_TRAP)
      pc_m = {mem[VEC_HI_ADDR], mem[VEC_LO_ADDR]};
    else
      pc_m = pc_m + 16'(step);
    rlog.delete();
    wlog.delete();
    @(posedge clk);
    go      <= 1'b1;
    opcode  <= op;
    prebyte <= pre;
    @(posedge clk);
    if (hold == 0)
      go <= 1'b0;
    opcode <= OP_ACC_TO_INDEX_LOW;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n == hold)
        go <= 1'b0;
      if (n == 1 && stall > 0)
        ce <= 1'b0;
      if (n == 1 + stall && stall > 0)
        ce <= 1'b1;
      #1;
      if (done !== 1'b1)
        cmp({15'h0000, busy}, 16'h0001, "busy");
    end
    while (done !== 1'b1 && n < 40);
    cmp(16'(n), 16'(cyc + stall), "cycles");
    cmp({15'h0000, busy}, 16'h0000, "busy at end");
    cmp(16'(rlog.size()), 16'(exp_rd.size()), "read count");
    foreach (exp_rd[i])
      cmp(rlog[i], exp_rd[i], "read address");
    cmp(16'(wlog.size()), 16'(exp_wr.size()), "push count");
    foreach (exp_wr[i])
    begin
      cmp(wlog[i][39:24], exp_wr[i][23:8], "push address");
      cmp({8'h00, wlog[i][23:16]}, {8'h00, exp_wr[i][7:0]}, "push data");
      cmp(wlog[i][15:0], exp_wr[i][23:8] - ONE16, "sp at push");
    end
    cmp({acc, flags}, {acc_m, flg_m}, "acc flags");
    cmp(idx, idx_m, "index");
    cmp(sp, sp_m, "sp");
    cmp(pc, pc_m, "pc");
  endtask : exec

  // operand byte, then target byte, then the test itself
  task automatic tst_mem(input logic [7:0] op, input logic pre,
                         input logic [7:0] val);
    mem[pc_m + ONE16] = 8'h10;
    mem[pc_m + TWO16] = 8'h10;
    if (op == OP_CHECK_DIR)
      mem[16'h0010] = val;
    else if (op == OP_CHECK_XPTR)
      mem[idx_m] = val;
    else
      mem[(pre ? sp_m : idx_m) + 16'h0010] = val;
    exec(op, pre, 0, 0);
  endtask : tst_mem

  task automatic s_first;
    exec(OP_SOFT_TRAP, 1'b0, 0, 0);
    exec(OP_STACKPTR_TO_INDEX, 1'b0, 0, 0);
    exec(OP_INDEX_LOW_TO_ACC, 1'b0, 0, 0);
    exec(OP_ACC_TO_FLAGS, 1'b0, 0, 0);
    exec(OP_CHECK_ACC, 1'b0, 0, 0);
  endtask : s_first

  task automatic s_mask;
    exec(OP_SOFT_TRAP, 1'b0, 0, 0);
    exec(OP_STACKPTR_TO_INDEX, 1'b0, 0, 3);
    exec(OP_INDEX_LOW_TO_ACC, 1'b0, 0, 0);
    exec(OP_ACC_TO_FLAGS, 1'b0, 0, 0);
    exec(OP_SOFT_TRAP, 1'b0, 5, 0);
    exec(OP_FLAGS_TO_ACC, 1'b0, 0, 0);
    exec(OP_ACC_TO_INDEX_LOW, 1'b0, 0, 0);
    exec(OP_INDEX_TO_STACKPTR, 1'b0, 0, 0);
  endtask : s_mask

  task automatic s_tests;
    logic [7:0] vals [3];
    vals = '{8'h80, 8'h00, 8'h7F};
    exec(OP_CHECK_ACC, 1'b0, 0, 0);
    exec(OP_CHECK_IDX, 1'b0, 0, 0);
    foreach (vals[i])
    begin
      tst_mem(OP_CHECK_DIR, 1'b0, vals[i]);
      tst_mem(OP_CHECK_XOFS, 1'b0, vals[i]);
      tst_mem(OP_CHECK_XPTR, 1'b0, vals[i]);
      tst_mem(OP_CHECK_SOFS, 1'b1, vals[i]);
    end
    exec(8'h9D, 1'b0, 0, 0);
  endtask : s_tests

  // wrap-around boundaries after a second reset
  task automatic s_wrap;
    exec(OP_INDEX_TO_STACKPTR, 1'b0, 0, 0);
    exec(OP_STACKPTR_TO_INDEX, 1'b0, 0, 0);
    exec(OP_FLAGS_TO_ACC, 1'b0, 0, 0);
    exec(OP_ACC_TO_INDEX_LOW, 1'b0, 0, 0);
  endtask : s_wrap

  initial
  begin
    repeat (4000) @(posedge clk);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    arst_n  = 1'b0;
    ce      = 1'b1;
    go      = 1'b0;
    opcode  = 8'h00;
    prebyte = 1'b0;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
    mem[VEC_HI_ADDR] = 8'h20;
    mem[VEC_LO_ADDR] = 8'h00;
    do_reset();
    s_first();
    s_mask();
    s_tests();
    do_reset();
    s_wrap();
    final_report();
  end
endmodule : cx_exec_unit_tb
